//--- dv/ccr_card_model.sv
`timescale 1ns/1ps
module ccr_card_model
   import ccr_pkg::*;
(
   output logic card_clk, // still low between frames
   output logic card_io // pulled high when idle
);
   initial begin
      card_clk = 1'b0;
      card_io = 1'b1;
   end
   // sync frame, LSB first, one rise per bit; odd offset keeps phase unrelated
   task automatic send(input logic [8:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         card_io = bits[i];
         #77 card_clk = 1'b1;
         #160 card_clk = 1'b0;
         #83;
      end
      card_io = 1'b1;
      #800;
   endtask
   // async character, start bit first; clock runs only inside the frame
   task automatic send_async(input logic [9:0] bits);
      for (int i = 0; i < 10; i++) begin
         card_io = bits[i];
         repeat (ETU_CLKS) begin
            #77 card_clk = 1'b1;
            #160 card_clk = 1'b0;
            #83;
         end
      end
      card_io = 1'b1;
      #800;
   endtask
endmodule

//--- dv/ccr_rx_monitor.sv
`timescale 1ns/1ps
module ccr_rx_monitor
   import ccr_pkg::*;
(
   input wire logic clk, // block clock
   input wire logic rst_b, // async reset
   input wire logic card_clk, // card clock
   input wire logic rx_error_event, // error level
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bready, // b ready
   input wire logic [31:0] s_axi_araddr, // ar addr
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic [1:0] s_axi_rresp, // r resp
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready // r ready
);
   localparam logic [31:0] A_CTL = {14'h0, RX_CTL_IDX, 2'b00};
   localparam logic [31:0] A_TOP = {14'h0, RX_MODE_IDX, 2'b00};
   logic [3:0] idle_cnt;
   wire ar_go = s_axi_arvalid && s_axi_arready;
   wire ctl_rd = ar_go && s_axi_araddr == A_CTL;
   wire mapped = s_axi_araddr >= A_CTL && s_axi_araddr <= A_TOP && s_axi_araddr[1:0] == 2'b00;
   // a byte may still land a few cycles after a card clock rise
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) idle_cnt <= 4'h0;
      else if (card_clk) idle_cnt <= 4'h0;
      else if (idle_cnt != 4'hF) idle_cnt <= idle_cnt + 4'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_AW_PAIR: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
      else $error("write ready wrong");
   AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_NEXT: assert property (ar_go |=> s_axi_rvalid)
      else $error("read response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read upper bits set");
   AST_R_UNMAP: assert property (ar_go && !mapped |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   AST_ERR_HOLD: assert property (rx_error_event && !ctl_rd |=> rx_error_event)
      else $error("error event lost");
   AST_ERR_CLR: assert property (ctl_rd && idle_cnt == 4'hF |=> !rx_error_event)
      else $error("error event not cleared");
   cover property (ctl_rd && rx_error_event);
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (ar_go && !mapped);
endmodule

//--- dv/ccr_rx_tb.sv
`timescale 1ns/1ps
module ccr_rx_tb
   import ccr_pkg::*;
;
   localparam logic [31:0] A_CTL = {14'h0, RX_CTL_IDX, 2'b00};
   localparam logic [31:0] A_DAT = {14'h0, RX_DATA_IDX, 2'b00};
   localparam logic [31:0] A_CRD = {14'h0, CARD_CTL_IDX, 2'b00};
   localparam logic [31:0] A_MOD = {14'h0, RX_MODE_IDX, 2'b00};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic card_clk, card_io, rx_error_event;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
   logic [31:0] s_axi_rdata, rd_data;
   logic [7:0] drain [7] = '{8'h5A, 8'h5A, 8'h33, 8'h00, 8'h00, 8'h00, 8'hA5};
   int err_total = 0;
   int compares = 0;
   ccr_rx u_ccr_rx (.clk, .rst_b, .card_clk, .card_io, .rx_error_event, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   ccr_card_model u_ccr_card_model (.card_clk, .card_io);
   initial forever #20 clk = ~clk;
   task automatic give_verdict();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic await(ref logic s);
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (s !== 1'b1 && n < 64);
      if (s !== 1'b1) begin
         err_total++;
         give_verdict();
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      int n = 0;
      logic aw_open = 1'b1;
      logic w_open = 1'b1;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      // each channel is released at its own ready
      do begin
         @(posedge clk);
         n++;
         if (aw_open && s_axi_awready === 1'b1) begin
            s_axi_awvalid <= 1'b0;
            aw_open = 1'b0;
         end
         if (w_open && s_axi_wready === 1'b1) begin
            s_axi_wvalid <= 1'b0;
            w_open = 1'b0;
         end
      end while ((aw_open || w_open) && n < 64);
      if (aw_open || w_open) begin
         err_total++;
         give_verdict();
      end
      // late ready keeps the response waiting for a cycle
      await(s_axi_bvalid);
      s_axi_bready <= 1'b1;
      await(s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      await(s_axi_arready);
      s_axi_arvalid <= 1'b0;
      await(s_axi_rvalid);
      s_axi_rready <= 1'b1;
      await(s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      chk(rd_data, {24'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      rd(A_CTL, 8'h04);
      rd(A_DAT, 8'h00);
      rd(A_CRD, 8'h21);
      rd(32'h0003F840, 8'h00);
      chk_resp(rd_resp, RESP_SLVERR);
      wr(A_CRD, 8'h5C);
      rd(A_CRD, 8'h5C);
      wr(A_DAT, 8'hFF);
      rd(A_DAT, 8'h00);
      wr(A_MOD, 8'h01);
      for (int k = 0; k < 8; k++) u_ccr_card_model.send({1'b0, 8'h30 + 8'(k)}, 8);
      rd(A_CTL, 8'h08);
      for (int k = 0; k < 2; k++) u_ccr_card_model.send(9'h0EE, 8);
      chk({31'h0, rx_error_event}, 32'h1);
      rd(A_DAT, 8'h30);
      // room again, but the pending overrun must still drop this byte
      u_ccr_card_model.send(9'h0EE, 8);
      rd(A_CTL, 8'h02);
      rd(A_CTL, 8'h00);
      chk({31'h0, rx_error_event}, 32'h0);
      for (int k = 1; k < 8; k++) rd(A_DAT, 8'h30 + 8'(k));
      rd(A_CTL, 8'h04);
      // lrc: matching pair passes, then a lone byte fails
      wr(A_MOD, 8'h05);
      u_ccr_card_model.send(9'h05A, 8);
      wr(A_CTL, 8'h20);
      u_ccr_card_model.send(9'h05A, 8);
      rd(A_CTL, 8'h00);
      wr(A_MOD, 8'h05);
      wr(A_CTL, 8'h20);
      u_ccr_card_model.send(9'h033, 8);
      rd(A_CTL, 8'h10);
      rd(A_CTL, 8'h00);
      wr(A_MOD, 8'h01);
      wr(A_CTL, 8'h20);
      u_ccr_card_model.send(9'h000, 8);
      rd(A_CTL, 8'h10);
      // two zero bytes from the initial value leave exactly the good residue
      u_ccr_card_model.send(9'h000, 8);
      wr(A_CTL, 8'h20);
      u_ccr_card_model.send(9'h000, 8);
      rd(A_CTL, 8'h00);
      wr(A_MOD, 8'h03);
      u_ccr_card_model.send(9'h1A5, 9);
      rd(A_CTL, 8'h80);
      for (int k = 0; k < 7; k++) rd(A_DAT, drain[k]);
      rd(A_CTL, 8'h84);
      // async character: odd count of ones over data and parity bit
      wr(A_MOD, 8'h00);
      u_ccr_card_model.send_async(10'h266);
      chk({31'h0, rx_error_event}, 32'h1);
      rd(A_CTL, 8'h81);
      rd(A_CTL, 8'h80);
      chk({31'h0, rx_error_event}, 32'h0);
      rd(A_DAT, 8'h33);
      give_verdict();
   end
endmodule
bind ccr_rx ccr_rx_monitor u_ccr_rx_monitor (.clk, .rst_b, .card_clk, .rx_error_event,
   .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

//--- hw/ccr_rx.sv
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module ccr_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input wire logic clk, // block clock
   input wire logic rst_sync_b, // synchronised reset
   input wire logic in_valid, // write strobe
   output logic in_ready, // room left
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid, // word waiting
   input wire logic out_ready, // pop strobe
   output logic [W-1:0] out_data // oldest word
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   assign in_ready = (count != (AW+1)'(D));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(D-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(D-1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module ccr_rx
   import ccr_pkg::*;
(
   input wire logic clk, // 25 MHz block clock
   input wire logic rst_b, // async reset, active low
   input wire logic card_clk, // card clock, foreign domain
   input wire logic card_io, // card data line, foreign domain
   output logic rx_error_event, // overrun or parity fault pending
   input wire logic [31:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [31:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   logic [1:0] rst_pipe;
   logic rst_sync_b;
   logic [1:0] clk_pipe;
   logic [1:0] io_pipe;
   logic clk_prev;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_b = rst_pipe[1];

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         clk_pipe <= 2'h0;
         io_pipe <= 2'h3;
         clk_prev <= 1'b0;
      end else begin
         clk_pipe <= {clk_pipe[0], card_clk};
         io_pipe <= {io_pipe[0], card_io};
         clk_prev <= clk_pipe[1];
      end
   end
   wire card_rise = clk_pipe[1] & ~clk_prev;
   wire io_s = io_pipe[1];

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] card_control;
   logic [7:0] rx_mode;
   logic final_rx_byte_flag;
   logic check_code_error;
   logic rx_overflow;
   logic rx_parity_fault;
   logic ninth_bit_sample;
   logic [15:0] crc_acc;
   logic [7:0] lrc_acc;
   wire sync_mode = rx_mode[MODE_SYNC];
   wire nine_bit_format_select = rx_mode[MODE_NINE];
   wire use_lrc = rx_mode[MODE_LRC];

   ////////////////////////////////////////////////////////////////////////////
   // receiver: sync mode shifts on every card clock rise, async on etu centres
   ccr_rx_state_t state;
   logic [8:0] etu_cnt;
   logic [3:0] bit_idx;
   logic [7:0] shreg;
   logic par_acc;
   ccr_rx_byte_t rx_byte;
   wire [3:0] sync_last = nine_bit_format_select ? SYNC_LAST9 : SYNC_LAST8;
   wire async_sample = card_rise & (etu_cnt == ETU_HALF);
   wire take_bit = sync_mode ? card_rise : async_sample;
   wire last_bit = sync_mode ? (bit_idx == sync_last) : (bit_idx == ASYNC_LAST_BIT);
   wire data_bit = sync_mode ? (bit_idx < 4'h8) : (bit_idx != 4'h0 && bit_idx < 4'h9);
   wire false_start = ~sync_mode & (bit_idx == 4'h0) & io_s;
   wire [7:0] next_shreg = data_bit ? {io_s, shreg[7:1]} : shreg;
   wire next_par = par_acc ^ (sync_mode ? 1'b0 : (io_s & (bit_idx != 4'h0)));

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state <= ST_IDLE;
         etu_cnt <= '0;
         bit_idx <= '0;
         shreg <= RX_DATA_RST;
         par_acc <= 1'b0;
         rx_byte <= '0;
         ninth_bit_sample <= 1'b0;
      end else begin
         rx_byte.done <= 1'b0;
         case (state)
            ST_IDLE: begin
               etu_cnt <= '0;
               bit_idx <= '0;
               par_acc <= 1'b0;
               // async waits for a start bit; sync begins at once
               if (sync_mode || (card_rise && !io_s)) begin
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (card_rise) begin
                  etu_cnt <= (etu_cnt == ETU_CLKS - 9'h001) ? '0 : etu_cnt + 9'h001;
               end
               if (take_bit) begin
                  shreg <= next_shreg;
                  par_acc <= next_par;
                  bit_idx <= bit_idx + 4'h1;
                  if (sync_mode && nine_bit_format_select && bit_idx == SYNC_LAST9) begin
                     ninth_bit_sample <= io_s;
                  end
                  if (false_start) begin
                     state <= ST_IDLE;
                  end else if (last_bit) begin
                     rx_byte.done <= 1'b1;
                     rx_byte.data <= next_shreg;
                     rx_byte.parity_bad <= next_par; // even parity over data and parity bit
                     state <= ST_IDLE;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive queue
   logic q_in_ready;
   logic q_out_valid;
   logic [7:0] q_out_data;
   logic rd_data_pop;
   // overrun locks the queue so firmware sees which bytes predate it
   wire q_push = rx_byte.done & q_in_ready & ~rx_overflow;
   wire ovr_set = rx_byte.done & ~q_in_ready;
   wire rx_queue_full = ~q_in_ready;
   wire rx_queue_empty = ~q_out_valid;

   ccr_fifo #(.W(RXQ_WIDTH), .D(RXQ_DEPTH)) u_rxq (
      .clk(clk),
      .rst_sync_b(rst_sync_b),
      .in_valid(q_push),
      .in_ready(q_in_ready),
      .in_data(rx_byte.data),
      .out_valid(q_out_valid),
      .out_ready(rd_data_pop),
      .out_data(q_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // check code over every received character, including those dropped by overrun
   wire [15:0] crc_next = crc_byte(crc_acc, rx_byte.data);
   wire [7:0] lrc_next = lrc_acc ^ rx_byte.data;
   wire check_now = rx_byte.done & final_rx_byte_flag;
   wire crc_bad = use_lrc ? (lrc_next != LRC_GOOD) : (crc_next != CRC_GOOD);

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave, one write and one read outstanding
   wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
   wire wr_hi_ok = (s_axi_awaddr[31:18] == 14'h0000) & (s_axi_awaddr[1:0] == 2'h0);
   wire rd_hi_ok = (s_axi_araddr[31:18] == 14'h0000) & (s_axi_araddr[1:0] == 2'h0);
   wire wr_ctl = wr_take & wr_hi_ok & (s_axi_awaddr[17:2] == RX_CTL_IDX);
   wire wr_card = wr_take & wr_hi_ok & (s_axi_awaddr[17:2] == CARD_CTL_IDX);
   wire wr_mode = wr_take & wr_hi_ok & (s_axi_awaddr[17:2] == RX_MODE_IDX);
   wire wr_data = wr_take & wr_hi_ok & (s_axi_awaddr[17:2] == RX_DATA_IDX);
   wire wr_hit = wr_ctl | wr_card | wr_mode | wr_data;
   wire lane0 = s_axi_wstrb[0];
   wire rd_ctl = rd_take & rd_hi_ok & (s_axi_araddr[17:2] == RX_CTL_IDX);
   wire rd_data = rd_take & rd_hi_ok & (s_axi_araddr[17:2] == RX_DATA_IDX);
   wire rd_card = rd_take & rd_hi_ok & (s_axi_araddr[17:2] == CARD_CTL_IDX);
   wire rd_mode = rd_take & rd_hi_ok & (s_axi_araddr[17:2] == RX_MODE_IDX);
   wire rd_hit = rd_ctl | rd_data | rd_card | rd_mode;
   assign rd_data_pop = rd_data & q_out_valid;
   wire [7:0] ctl_view = {ninth_bit_sample, 1'b0, final_rx_byte_flag, check_code_error,
                          rx_queue_full, rx_queue_empty, rx_overflow, rx_parity_fault};
   wire [7:0] data_view = q_out_valid ? q_out_data : RX_DATA_RST;
   wire [7:0] rd_sel = rd_ctl ? ctl_view : rd_data ? data_view :
                       rd_card ? card_control : rd_mode ? rx_mode : 8'h00;
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_arready = rd_take;
   assign rx_error_event = rx_overflow | rx_parity_fault;

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
      end else begin
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= {24'h000000, rd_sel};
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags: a hardware set in the clearing cycle wins
   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         card_control <= CARD_CTL_RST;
         rx_mode <= RX_MODE_RST;
         final_rx_byte_flag <= RX_CTL_RST[BIT_FINAL];
         check_code_error <= RX_CTL_RST[BIT_CHKERR];
         rx_overflow <= RX_CTL_RST[BIT_OVR];
         rx_parity_fault <= RX_CTL_RST[BIT_PAR];
         crc_acc <= CRC_INIT;
         lrc_acc <= LRC_GOOD;
      end else begin
         if (wr_card && lane0) begin
            card_control <= s_axi_wdata[7:0];
         end
         if (wr_mode && lane0) begin
            rx_mode <= s_axi_wdata[7:0];
         end
         if (wr_ctl && lane0) begin
            final_rx_byte_flag <= s_axi_wdata[BIT_FINAL];
         end else if (check_now) begin
            final_rx_byte_flag <= 1'b0;
         end
         rx_overflow <= ovr_set | (rx_overflow & ~rd_ctl);
         rx_parity_fault <= (rx_byte.done & rx_byte.parity_bad) | (rx_parity_fault & ~rd_ctl);
         check_code_error <= (check_now & crc_bad) | (check_code_error & ~rd_ctl);
         // accumulators restart after each message or on a mode register write with byte lane 0 enabled
         if ((wr_mode && lane0) || check_now) begin
            crc_acc <= CRC_INIT;
            lrc_acc <= LRC_GOOD;
         end else if (rx_byte.done) begin
            crc_acc <= crc_next;
            lrc_acc <= lrc_next;
         end
      end
   end
endmodule

//--- pkg/ccr_pkg.sv
// Functional notes
// - sync nine-bit mode: ninth card clock rising edge samples data line into ninth bit.
// - firmware marks final byte; at its end CRC must equal 0x1D0F, else error.
// - read-only check-code error bit shows any CRC or LRC mismatch.
// - read-only full bit is one while the receive queue holds its maximum.
// - read-only empty bit; it raises no receive interrupt.
// - byte arriving with queue full sets overrun; control read clears; error event raised.
// - while overrun is set every further byte is discarded.
// - parity failure sets parity fault; control read clears; error event raised.
// - received bytes enter the queue; firmware reads them from the data register.
// - control/status register at index 0xFE08, reads 0x04 after reset (empty bit set).
// - receive data register at index 0xFE09, reads zero after reset.
// - card control register at index 0xFE0A, reset value 0x21.
package ccr_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] RX_CTL_IDX = 16'hFE08;
   localparam logic [15:0] RX_DATA_IDX = 16'hFE09;
   localparam logic [15:0] CARD_CTL_IDX = 16'hFE0A;
   localparam logic [15:0] RX_MODE_IDX = 16'hFE0B;
   localparam logic [7:0] RX_CTL_RST = 8'h00;
   localparam logic [7:0] RX_DATA_RST = 8'h00;
   localparam logic [7:0] CARD_CTL_RST = 8'h21;
   localparam logic [7:0] RX_MODE_RST = 8'h00;
   // control/status bit positions
   localparam int BIT_NINTH = 7;
   localparam int BIT_FINAL = 5;
   localparam int BIT_CHKERR = 4;
   localparam int BIT_FULL = 3;
   localparam int BIT_EMPTY = 2;
   localparam int BIT_OVR = 1;
   localparam int BIT_PAR = 0;
   // mode register bit positions
   localparam int MODE_SYNC = 0;
   localparam int MODE_NINE = 1;
   localparam int MODE_LRC = 2;
   // check codes
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_GOOD = 16'h1D0F;
   localparam logic [7:0] LRC_GOOD = 8'h00;
   // async character timing in card clocks
   localparam logic [8:0] ETU_CLKS = 9'h174;
   localparam logic [8:0] ETU_HALF = 9'h0BA;
   localparam logic [3:0] ASYNC_LAST_BIT = 4'h9;
   localparam logic [3:0] SYNC_LAST8 = 4'h7;
   localparam logic [3:0] SYNC_LAST9 = 4'h8;
   localparam int RXQ_DEPTH = 8;
   localparam int RXQ_WIDTH = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SHIFT = 2'b10
   } ccr_rx_state_t;

   typedef struct packed {
      logic done;
      logic parity_bad;
      logic [7:0] data;
   } ccr_rx_byte_t;
endpackage
